// >>> logic/sof_timed_watchdog_pkg.sv
// constants for the frame-timed watchdog
package sof_timed_watchdog_pkg;
  localparam logic [15:0] WATCHDOG_CONTROL_STATUS_ADDR = 16'hff93;
  localparam int KICK_BIT_POS = 0;
  localparam int DISABLE_UPPER_LSB = 1;
  localparam int DISABLE_UPPER_MSB = 5;
  localparam int RESET_CAUSE_POS = 6;
  localparam int DISABLE_LOW_POS = 7;
  localparam logic [4:0] DISABLE_UPPER_RESET = 5'h00;
  localparam logic DISABLE_LOW_RESET = 1'b1;
  localparam logic [4:0] DISABLE_UPPER_KEY = 5'h15;
  localparam logic DISABLE_LOW_KEY = 1'b0;
  localparam int TIMEOUT_MS = 128;
  localparam int TICK_MS = 1;
  localparam int COUNT_WIDTH = 7;
  localparam int TIMEOUT_TICKS = TIMEOUT_MS / TICK_MS;
endpackage

// >>> logic/frame_tick_counter.sv
// 7-bit millisecond counter stepped by synchronised frame pulses
`timescale 1ns/1ps
`default_nettype none
module frame_tick_counter
  import sof_timed_watchdog_pkg::*;
#(
  parameter int WIDTH = COUNT_WIDTH
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_clear,
  input wire logic i_tick,
  output logic o_wrap
);
  if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
    $error("frame_tick_counter: unsupported width");
  end

  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] nxt_count;
  logic [WIDTH-1:0] all_ones;
  assign all_ones = '1;
  // wrap when the last millisecond of the window elapses
  assign o_wrap = i_tick && !i_clear && (count_ff == all_ones);
  assign nxt_count = i_clear ? '0 : (i_tick ? count_ff + 1'b1 : count_ff);

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end
endmodule
`default_nettype wire

// >>> logic/sof_timed_watchdog.sv
// watchdog timed by usb start-of-frame pulses, with its control and status register
`timescale 1ns/1ps
`default_nettype none
// Operation
// - one millisecond tick comes from frame pulses
// - count only while usb connect bit set
// - reset core after 128 ms without kick
// - watchdog runs from reset, no setup
// - disabled only by pattern 101010b
// - writing one to kick restarts period
// - kick bit always reads zero
// - timeout counter is seven bits wide
// - reset cause set after watchdog reset
// - writing one clears reset cause
// - watchdog reset clears memory shadow bit
module sof_timed_watchdog
  import sof_timed_watchdog_pkg::*;
#(
  parameter int TICK_COUNT_WIDTH = COUNT_WIDTH,
  parameter int SYNC_STAGES = 2
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_sof_pulse,
  input wire logic i_usb_connect_bit,
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_watchdog_reset,
  output logic o_memory_shadow_clear
);
  // elaboration-time checks
  // fewer than two stages would let a metastable level reach the edge detector
  if (SYNC_STAGES < 2 || SYNC_STAGES > 4) begin : g_bad_sync_depth
    $error("sof_timed_watchdog: unsupported synchroniser depth");
  end

  // the timeout is the counter's wrap, so its width sets the period
  if (TICK_COUNT_WIDTH < 1 || TICK_COUNT_WIDTH > 16) begin : g_bad_count_width
    $error("sof_timed_watchdog: unsupported counter width");
  end

  // one wrap of the counter must span exactly the timeout window
  if ((1 << TICK_COUNT_WIDTH) != TIMEOUT_TICKS) begin : g_bad_window
    $error("sof_timed_watchdog: counter width does not match the timeout");
  end

  // the four fields must tile the byte; an overlap would double-drive the read value
  if (DISABLE_UPPER_LSB != KICK_BIT_POS + 1 || RESET_CAUSE_POS != DISABLE_UPPER_MSB + 1 ||
      DISABLE_LOW_POS != RESET_CAUSE_POS + 1 || DISABLE_LOW_POS != 7) begin : g_bad_field_map
    $error("sof_timed_watchdog: register fields do not tile the byte");
  end

  // a reset pattern equal to the key would leave the timer stopped from power-up
  if ((DISABLE_UPPER_RESET == DISABLE_UPPER_KEY) &&
      (DISABLE_LOW_RESET == DISABLE_LOW_KEY)) begin : g_bad_key
    $error("sof_timed_watchdog: reset pattern already disables the timer");
  end

  // frame pulse and connect level come from the usb engine domain, each through its own chain
  localparam int NUM_ASYNC = 2;
  localparam int SOF_IDX = 0;
  localparam int CONNECT_IDX = 1;
  logic [NUM_ASYNC-1:0] async_in;
  logic [NUM_ASYNC-1:0] async_sync;
  assign async_in = {i_usb_connect_bit, i_sof_pulse};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_ASYNC; gi++) begin : g_sync
      logic [SYNC_STAGES-1:0] chain_ff;
      logic [SYNC_STAGES-1:0] nxt_chain;
      assign nxt_chain = {chain_ff[SYNC_STAGES-2:0], async_in[gi]};
      always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
          chain_ff <= '0;
        end else begin
          chain_ff <= nxt_chain;
        end
      end
      // only the last stage is read; earlier ones may still be settling
      assign async_sync[gi] = chain_ff[SYNC_STAGES-1];
    end
  endgenerate

  logic sof_sync;
  logic sof_prev_ff;
  logic connect_sync;
  assign sof_sync = async_sync[SOF_IDX];
  assign connect_sync = async_sync[CONNECT_IDX];

  // previous level resets to the idle low of the pin, so no false edge follows reset
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sof_prev_ff <= 1'b0;
    end else begin
      sof_prev_ff <= sof_sync;
    end
  end

  // rising edge of the synchronised pulse marks one millisecond
  // without connect no frames reach us, so gate the tick as well
  logic ms_tick;
  assign ms_tick = sof_sync && !sof_prev_ff && connect_sync;

  // register fields
  logic [4:0] disable_pattern_upper_ff;
  logic disable_pattern_low_ff;
  logic watchdog_reset_cause_ff;
  logic watchdog_reset_ff;

  // bus decode
  logic reg_hit;
  logic reg_write;
  logic reg_read;
  logic kick;
  logic cause_clear;
  logic wd_enabled;
  logic timeout;
  logic timeout_reset;
  logic counter_clear;
  logic field_reset;

  assign reg_hit = (i_addr == WATCHDOG_CONTROL_STATUS_ADDR);
  assign reg_write = reg_hit && i_wr;
  assign reg_read = reg_hit && i_rd;
  assign kick = reg_write && i_wdata[KICK_BIT_POS];
  assign cause_clear = reg_write && i_wdata[RESET_CAUSE_POS];
  assign wd_enabled = !((disable_pattern_upper_ff == DISABLE_UPPER_KEY) &&
                        (disable_pattern_low_ff == DISABLE_LOW_KEY));
  assign timeout_reset = timeout && wd_enabled;
  // a kick or a disabled timer restarts the full window from zero
  assign counter_clear = kick || !wd_enabled || watchdog_reset_ff;
  // the disable fields return to the running pattern on either reset
  assign field_reset = !i_resetn || watchdog_reset_ff;

  // writes land at the strobe edge
  logic [4:0] nxt_disable_pattern_upper;
  logic nxt_disable_pattern_low;
  logic nxt_watchdog_reset_cause;

  assign nxt_disable_pattern_upper = reg_write ? i_wdata[DISABLE_UPPER_MSB:DISABLE_UPPER_LSB]
                                               : disable_pattern_upper_ff;
  assign nxt_disable_pattern_low = reg_write ? i_wdata[DISABLE_LOW_POS] : disable_pattern_low_ff;
  // a timeout in the same cycle as a clear keeps the flag set
  assign nxt_watchdog_reset_cause = timeout ? 1'b1 :
                                    (cause_clear ? 1'b0 : watchdog_reset_cause_ff);

  // a wrap that meets a kick loses, so a late kick still saves the core
  frame_tick_counter #(
    .WIDTH(TICK_COUNT_WIDTH)
  ) u_counter (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_clear(counter_clear),
    .i_tick(ms_tick),
    .o_wrap(timeout)
  );

  // cause flag survives the watchdog reset; only the external reset or a write of one to the cause bit clears it
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      watchdog_reset_cause_ff <= 1'b0;
    end else begin
      watchdog_reset_cause_ff <= nxt_watchdog_reset_cause;
    end
  end

  // one-cycle pulse; the core and the shadow bit both take it
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      watchdog_reset_ff <= 1'b0;
    end else begin
      watchdog_reset_ff <= timeout_reset;
    end
  end

  always_ff @(posedge i_clk) begin
    if (field_reset) begin
      disable_pattern_upper_ff <= DISABLE_UPPER_RESET;
    end else begin
      disable_pattern_upper_ff <= nxt_disable_pattern_upper;
    end
  end

  // low bit resets to one, so a reset register always runs the timer
  always_ff @(posedge i_clk) begin
    if (field_reset) begin
      disable_pattern_low_ff <= DISABLE_LOW_RESET;
    end else begin
      disable_pattern_low_ff <= nxt_disable_pattern_low;
    end
  end

  // read value built from the field positions
  logic [7:0] read_value;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  assign read_value[KICK_BIT_POS] = 1'b0;
  assign read_value[DISABLE_UPPER_MSB:DISABLE_UPPER_LSB] = disable_pattern_upper_ff;
  assign read_value[RESET_CAUSE_POS] = watchdog_reset_cause_ff;
  assign read_value[DISABLE_LOW_POS] = disable_pattern_low_ff;
  // data reads zero outside the strobe, so a stale value never lingers on the bus
  assign nxt_rdata = reg_read ? read_value : 8'h00;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // outputs
  assign o_rdata = rdata_ff;
  assign o_watchdog_reset = watchdog_reset_ff;
  assign o_memory_shadow_clear = watchdog_reset_ff;
endmodule
`default_nettype wire

// >>> tb/sof_timed_watchdog_properties.sv
// port assertions for the watchdog
`timescale 1ns/1ps
`default_nettype none
module sof_timed_watchdog_properties
  import sof_timed_watchdog_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_sof_pulse,
  input wire logic i_usb_connect_bit,
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_watchdog_reset,
  input wire logic o_memory_shadow_clear
);
  wire hit = i_addr == WATCHDOG_CONTROL_STATUS_ADDR;
  wire kick = i_wr && hit && i_wdata[0];
  wire off = i_wr && hit && i_wdata[7:1] == 7'h15;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // a timeout already launched may still show one cycle later
  sequence s_quiet;
    ##2 !o_watchdog_reset [*8];
  endsequence
  a_shadow_with_reset: assert property (o_memory_shadow_clear == o_watchdog_reset)
    else $error("shadow clear differs");
  a_reset_one_cycle: assert property (o_watchdog_reset |=> !o_watchdog_reset)
    else $error("reset pulse too long");
  a_kick_reads_zero: assert property (i_rd && hit |=> !o_rdata[0])
    else $error("kick bit read as one");
  a_kick_holds_off: assert property (kick |-> s_quiet)
    else $error("reset right after kick");
  a_disable_holds_off: assert property (off |-> s_quiet)
    else $error("reset after disable");
  a_cause_after_reset: assert property ((o_watchdog_reset && !i_wr) ##1 (i_rd && hit && !i_wr) |=> o_rdata == 8'hc0)
    else $error("register wrong after timeout");
  a_bad_addr_zero: assert property (i_rd && !hit |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_no_tick_offline: assert property (!i_usb_connect_bit [*8] |-> !o_watchdog_reset)
    else $error("reset while disconnected");
endmodule
`default_nettype wire

// >>> tb/sof_source.sv
// frame pulse source standing in for the usb engine
`timescale 1ns/1ps
`default_nettype none
module sof_source (
  input wire logic i_clk,
  input wire logic i_en,
  output logic o_sof
);
  logic [2:0] cnt_ff = 3'h0;
  logic en_ff = 1'b0;
  // enable only changes between pulses so no pulse is cut short
  always_ff @(posedge i_clk) begin
    cnt_ff <= cnt_ff + 3'h1;
    if (cnt_ff == 3'h7) en_ff <= i_en;
  end
  assign o_sof = en_ff & cnt_ff[2];
endmodule
`default_nettype wire

// >>> tb/sof_timed_watchdog_tb_top.sv
// self-checking bench for the frame-timed watchdog
`timescale 1ns/1ps
`default_nettype none
module sof_timed_watchdog_tb_top;
  logic clk = 0, resetn = 0, wr = 0, rd = 0, con = 0, en = 0, sof, watchdog_reset_cause, shc;
  logic [15:0] addr = 16'hff93;
  logic [7:0] wdata = 8'h00, rdata;
  int bad_count = 0, check_count = 0;
  always #10 clk = ~clk;
  sof_source u_sof_source (.i_clk(clk), .i_en(en), .o_sof(sof));
  sof_timed_watchdog u_sof_timed_watchdog (.i_clk(clk), .i_resetn(resetn), .i_sof_pulse(sof),
    .i_usb_connect_bit(con), .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata),
    .o_watchdog_reset(watchdog_reset_cause), .o_memory_shadow_clear(shc));
  task automatic cmp(string n, logic [7:0] e, logic [7:0] s);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wt(logic [7:0] v);
    @(negedge clk);
    wdata = v;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask
  task automatic rt(logic [7:0] e);
    @(negedge clk);
    rd = 1;
    @(negedge clk);
    rd = 0;
    cmp("register", e, rdata);
  endtask
  // counts reset pulses over a fixed stretch, sof every 8 cycles
  task automatic run(int n, logic [7:0] e);
    logic [7:0] k;
    logic [7:0] m;
    k = 0;
    m = 0;
    // sampled mid-cycle, where the registered pulse has settled
    repeat (n) begin
      @(negedge clk);
      k += {7'h00, watchdog_reset_cause === 1'b1};
      m += {7'h00, shc === 1'b1};
    end
    cmp("resets", e, k);
    cmp("shadow clears", e, m);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    resetn = 1;
    rt(8'h80);
    addr = 16'hff92;
    rt(8'h00);
    addr = 16'hff93;
    con = 1;
    en = 1;
    wt(8'h01);
    run(1000, 0);
    wt(8'h01);
    run(1000, 0);
    wt(8'h00);
    run(100, 1);
    wt(8'h80);
    rt(8'hc0);
    wt(8'hc0);
    rt(8'h80);
    wt(8'h2b);
    rt(8'h2a);
    run(1200, 0);
    wt(8'hab);
    run(1100, 1);
    con = 0;
    wt(8'h01);
    run(1200, 0);
    resetn = 0;
    repeat (2) @(negedge clk);
    resetn = 1;
    rt(8'h80);
    end_of_test();
  end
endmodule
bind sof_timed_watchdog sof_timed_watchdog_properties u_props (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_sof_pulse(i_sof_pulse), .i_usb_connect_bit(i_usb_connect_bit), .i_addr(i_addr), .i_wr(i_wr),
  .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_watchdog_reset(o_watchdog_reset),
  .o_memory_shadow_clear(o_memory_shadow_clear));
`default_nettype wire
